// ---- autoreload_timer_capture.sv ----
// auto-reload down-counter with capture, restart and wave outputs
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "autoreload_timer_params.svh"
module autoreload_timer_capture (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_tick,
    input wire logic event_in_a,
    input wire logic event_in_b,
    output logic pwm_out,
    output logic overflow_out,
    output logic irq,
    output logic [15:0] counter_value
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [`CTRL_WIDTH-1:0] ctrl_q;
    logic [`ST_WIDTH-1:0] int_en_q;
    logic [`ST_WIDTH-1:0] status_q;
    logic [`ST_WIDTH-1:0] status_d;
    logic [15:0] compare_reg;
    logic [15:0] mask_q;
    logic [15:0] reload_capture_reg;
    logic [15:0] capture_reg;
    logic [15:0] count_d;
    logic counting_q;
    logic counting_d;
    logic run_prev_q;
    logic upd_q;
    logic upd_d;
    logic edge_a;
    logic edge_b;
    logic setup_ph;
    logic wr_acc;
    logic mapped;
    logic [31:0] rdata_d;
    logic run_enable;
    logic reload_en;
    autoreload_timer_pkg::reload_sel_t sel;
    logic run_rise;
    logic mode_a;
    logic mode_b;
    logic mode_sw;
    logic a_reload;
    logic b_reload;
    logic a_cap;
    logic b_cap;
    logic a_err_set;
    logic b_err_set;
    logic ovf_ev;
    logic zero_ev;
    logic cmp_ev;
    logic [`ST_WIDTH-1:0] set_vec;
    logic [`ST_WIDTH-1:0] clr_vec;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // masked equality used for both compare paths
    function automatic logic masked_eq(input logic [15:0] a,
            input logic [15:0] b, input logic [15:0] m);
        masked_eq = ((a & m) == (b & m));
    endfunction

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------

    // mode fields from the control register
    assign run_enable = ctrl_q[`CTRL_RUN];
    assign reload_en = ctrl_q[`CTRL_RELOAD_EN];
    assign sel = autoreload_timer_pkg::reload_sel_t'(
        {ctrl_q[`CTRL_SEL_HI], ctrl_q[`CTRL_SEL_LO]});
    assign run_rise = run_enable & ~run_prev_q;
    assign mode_a = reload_en & (sel == autoreload_timer_pkg::sel_event_a);
    assign mode_b = reload_en & (sel == autoreload_timer_pkg::sel_event_b);
    assign mode_sw = reload_en & ((sel == autoreload_timer_pkg::sel_software)
        | (sel == autoreload_timer_pkg::sel_off));

    // ------------------------------------------------------------
    // event inputs
    // ------------------------------------------------------------

    // pin a synchroniser, gated by run_enable
    event_edge_sync sync_a (
        .pclk(pclk),
        .presetn(presetn),
        .enable(run_enable),
        .pin(event_in_a),
        .rising_sel(ctrl_q[`CTRL_EDGE_A]),
        .edge_pulse(edge_a)
    );

    // pin b synchroniser, gated by run_enable
    event_edge_sync sync_b (
        .pclk(pclk),
        .presetn(presetn),
        .enable(run_enable),
        .pin(event_in_b),
        .rising_sel(ctrl_q[`CTRL_EDGE_B]),
        .edge_pulse(edge_b)
    );

    // ------------------------------------------------------------
    // event actions
    // ------------------------------------------------------------

    // reloads from event pins in restart modes
    assign a_reload = edge_a & mode_a;
    assign b_reload = edge_b & mode_b;

    // a captures only in free run with both a flags clear
    assign a_cap = edge_a & ~reload_en & ~status_q[`ST_A_FLAG]
        & ~status_q[`ST_A_ERR];

    // b captures whenever both b flags are clear
    assign b_cap = edge_b & ~status_q[`ST_B_FLAG]
        & ~status_q[`ST_B_ERR];

    // repeat edge while flag still set raises the error
    assign a_err_set = edge_a & status_q[`ST_A_FLAG];
    assign b_err_set = edge_b & status_q[`ST_B_FLAG];

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------

    // zero overflow on a tick while counting
    assign ovf_ev = counting_q & count_tick & (counter_value == `RST_WORD);

    // start flag: run set starts free run and software restart
    assign counting_d = !run_enable ? 1'b0 :
        (run_rise & (~reload_en | mode_sw)) | a_reload | b_reload
        | counting_q;

    // next count; event reload uses old count for capture first
    assign count_d = !run_enable ? `RST_WORD :
        (a_reload | b_reload) ? reload_capture_reg :
        (run_rise & mode_sw) ? reload_capture_reg :
        ovf_ev ? (reload_en ? reload_capture_reg
            : `FREE_RUN_RELOAD) :
        (counting_q & count_tick) ? counter_value - 16'h0001 :
        counter_value;

    // marks a cycle whose count is newly loaded or decremented
    assign upd_d = run_enable & (count_d != counter_value
        | ovf_ev | a_reload | b_reload);

    // counter state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= `RST_WORD;
            counting_q <= 1'b0;
            run_prev_q <= 1'b0;
            upd_q <= 1'b0;
        end else begin
            counter_value <= count_d;
            counting_q <= counting_d;
            run_prev_q <= run_enable;
            upd_q <= upd_d;
        end
    end

    // ------------------------------------------------------------
    // masked compare events
    // ------------------------------------------------------------

    // one event each time a fresh count matches
    assign zero_ev = upd_q & masked_eq(counter_value, `RST_WORD, mask_q);
    assign cmp_ev = upd_q & masked_eq(counter_value, compare_reg, mask_q);

    // ------------------------------------------------------------
    // capture registers
    // ------------------------------------------------------------

    // captures take the count before any same-cycle reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_reg <= `RST_WORD;
        end else if (b_cap) begin
            capture_reg <= counter_value;
        end
    end

    // reload value written by software only while reload enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_capture_reg <= `RST_WORD;
        end else if (a_cap) begin
            reload_capture_reg <= counter_value;
        end else if (wr_acc & reload_en
                & paddr == `OFS_RELOAD_CAPTURE) begin
            reload_capture_reg <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------

    // hardware sets; a b edge in a-restart mode still only flags b
    assign set_vec[`ST_A_FLAG] = edge_a & (mode_a | ~status_q[`ST_A_ERR]);
    assign set_vec[`ST_A_ERR] = a_err_set;
    assign set_vec[`ST_B_FLAG] = b_cap;
    assign set_vec[`ST_B_ERR] = b_err_set;
    assign set_vec[`ST_OVF_FLAG] = ovf_ev;
    assign set_vec[`ST_CMP_FLAG] = cmp_ev;
    assign set_vec[`ST_ZERO_FLAG] = zero_ev;

    // write one to clear; a set in the same cycle wins
    assign clr_vec = (wr_acc & paddr == `OFS_STATUS)
        ? pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};
    assign status_d = set_vec | (status_q & ~clr_vec);

    // flag register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= {`ST_WIDTH{1'b0}};
        end else begin
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------

    // registered OR of enabled flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & int_en_q);
        end
    end

    // ------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------

    // pwm and overflow pins; unaffected by captures
    timer_wave_out wave (
        .pclk(pclk),
        .presetn(presetn),
        .zero_ev(zero_ev),
        .cmp_ev(cmp_ev),
        .ovf_ev(ovf_ev),
        .ovf_flag(status_q[`ST_OVF_FLAG]),
        .pwm_en(ctrl_q[`CTRL_PWM_EN]),
        .pwm_toggle(ctrl_q[`CTRL_PWM_MODE]),
        .pwm_pol(ctrl_q[`CTRL_PWM_POL]),
        .ovf_toggle(ctrl_q[`CTRL_OVF_MODE]),
        .pwm_out(pwm_out),
        .overflow_out(overflow_out)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------

    // setup phase prepares the answer; access phase completes it
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
    assign mapped = (paddr[1:0] == 2'b00) & (paddr <= `OFS_COUNTER);

    // read mux
    assign rdata_d =
        (paddr == `OFS_CTRL) ? {22'h000000, ctrl_q} :
        (paddr == `OFS_INT_EN) ? {25'h0000000, int_en_q} :
        (paddr == `OFS_STATUS) ? {25'h0000000, status_q} :
        (paddr == `OFS_COMPARE) ? {16'h0000, compare_reg} :
        (paddr == `OFS_MASK) ? {16'h0000, mask_q} :
        (paddr == `OFS_RELOAD_CAPTURE) ? {16'h0000, reload_capture_reg} :
        (paddr == `OFS_CAPTURE) ? {16'h0000, capture_reg} :
        (paddr == `OFS_COUNTER) ? {16'h0000, counter_value} :
        32'h00000000;

    // answer registers: ready and data one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            prdata <= (setup_ph & ~pwrite) ? rdata_d : 32'h00000000;
        end
    end

    // software-written control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `RST_CTRL;
            int_en_q <= `RST_INT_EN;
            compare_reg <= `RST_WORD;
            mask_q <= `RST_MASK;
        end else if (wr_acc) begin
            if (paddr == `OFS_CTRL) begin
                ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
            end
            if (paddr == `OFS_INT_EN) begin
                int_en_q <= pwdata[`ST_WIDTH-1:0];
            end
            if (paddr == `OFS_COMPARE) begin
                compare_reg <= pwdata[15:0];
            end
            if (paddr == `OFS_MASK) begin
                mask_q <= pwdata[15:0];
            end
        end
    end
endmodule

// ---- autoreload_timer_params.svh ----
// constants of the auto-reload timer capture and output block
`ifndef AUTORELOAD_TIMER_PARAMS_SVH
`define AUTORELOAD_TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_INT_EN 8'h04
`define OFS_STATUS 8'h08
`define OFS_COMPARE 8'h0c
`define OFS_MASK 8'h10
`define OFS_RELOAD_CAPTURE 8'h14
`define OFS_CAPTURE 8'h18
`define OFS_COUNTER 8'h1c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_RELOAD_EN 1
`define CTRL_SEL_LO 2
`define CTRL_SEL_HI 3
`define CTRL_OVF_MODE 4
`define CTRL_PWM_EN 5
`define CTRL_PWM_MODE 6
`define CTRL_PWM_POL 7
`define CTRL_EDGE_A 8
`define CTRL_EDGE_B 9
`define CTRL_WIDTH 10

// ----------------------------------------------------------------
// status and interrupt enable fields
// ----------------------------------------------------------------
`define ST_A_FLAG 0
`define ST_A_ERR 1
`define ST_B_FLAG 2
`define ST_B_ERR 3
`define ST_OVF_FLAG 4
`define ST_CMP_FLAG 5
`define ST_ZERO_FLAG 6
`define ST_WIDTH 7

// ----------------------------------------------------------------
// reset and reload values
// ----------------------------------------------------------------
`define RST_CTRL 10'h000
`define RST_INT_EN 7'h00
`define RST_WORD 16'h0000
`define RST_MASK 16'hffff
`define FREE_RUN_RELOAD 16'hffff

`endif

// ---- autoreload_timer_pkg.sv ----
// types shared by the auto-reload timer capture and output block
package autoreload_timer_pkg;

    // reload source codes, {hi, lo}
    typedef enum logic [1:0] {
        sel_software = 2'b00,
        sel_event_a = 2'b01,
        sel_event_b = 2'b10,
        sel_off = 2'b11
    } reload_sel_t;

endpackage

// ---- event_edge_sync.sv ----
// three-stage synchroniser and polarity edge detector for one event pin
`timescale 1ns/1ps
module event_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic pin,
    input wire logic rising_sel,
    output logic edge_pulse
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;
    logic hit;

    // level only moves when the second and third stages agree
    assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    // rising when select is 1, falling when 0
    assign hit = enable & (lvl_d != lvl_q) & (lvl_d == rising_sel);

    // synchroniser chain, filtered level and single pulse per edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            edge_pulse <= hit;
        end
    end
endmodule

// ---- timer_wave_out.sv ----
// pwm and overflow output waveform generator
`timescale 1ns/1ps
module timer_wave_out (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic zero_ev,
    input wire logic cmp_ev,
    input wire logic ovf_ev,
    input wire logic ovf_flag,
    input wire logic pwm_en,
    input wire logic pwm_toggle,
    input wire logic pwm_pol,
    input wire logic ovf_toggle,
    output logic pwm_out,
    output logic overflow_out
);
    logic pwm_d;
    logic ovf_d;

    // pwm: idle level, set/reset from zero and compare, or toggle
    assign pwm_d = !pwm_en ? pwm_pol :
        pwm_toggle ? (cmp_ev ? ~pwm_out : pwm_out) :
        zero_ev ? pwm_pol :
        cmp_ev ? ~pwm_pol : pwm_out;

    // overflow: set until flag cleared, or toggle on each overflow
    assign ovf_d = ovf_toggle ? (overflow_out ^ ovf_ev) :
        (ovf_ev | (overflow_out & ovf_flag));

    // output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 1'b0;
            overflow_out <= 1'b0;
        end else begin
            pwm_out <= pwm_d;
            overflow_out <= ovf_d;
        end
    end
endmodule

// ---- autoreload_timer_checker.sv ----
// port level checks of the auto-reload timer block
`timescale 1ns/1ps
`include "autoreload_timer_params.svh"
module autoreload_timer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_tick,
    input wire logic event_in_a,
    input wire logic event_in_b,
    input wire logic pwm_out,
    input wire logic overflow_out,
    input wire logic irq,
    input wire logic [15:0] counter_value
);
    // ----------------------------------------
    // shadow of control and enable writes
    // ----------------------------------------
    logic [9:0] ctrl_q, ctrl_p1, ctrl_p2;
    logic [6:0] ien_q, ien_p1, ien_p2;
    logic wr_ok, steady, run, rel;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign steady = (ctrl_q == ctrl_p1) && (ctrl_p1 == ctrl_p2);
    assign run = ctrl_q[`CTRL_RUN];
    assign rel = ctrl_q[`CTRL_RELOAD_EN];

    // snoop accepted writes, keep two cycles of history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
            ctrl_p1 <= '0;
            ctrl_p2 <= '0;
            ien_q <= '0;
            ien_p1 <= '0;
            ien_p2 <= '0;
        end else begin
            if (wr_ok && paddr == `OFS_CTRL) ctrl_q <= pwdata[9:0];
            if (wr_ok && paddr == `OFS_INT_EN) ien_q <= pwdata[6:0];
            ctrl_p1 <= ctrl_q;
            ctrl_p2 <= ctrl_p1;
            ien_p1 <= ien_q;
            ien_p2 <= ien_p1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero when idle");
    a_stop_clears: assert property (
        steady && !run |-> counter_value == 16'h0)
        else $error("counter not cleared while stopped");
    a_free_step: assert property (
        steady && run && !rel && count_tick
        |=> counter_value == $past(counter_value) - 16'h1)
        else $error("free running step wrong");
    a_free_hold: assert property (
        steady && run && !rel && !count_tick |=> $stable(counter_value))
        else $error("counter moved without tick");
    a_pwm_off_level: assert property (
        steady && !ctrl_q[`CTRL_PWM_EN]
        |-> pwm_out == ctrl_q[`CTRL_PWM_POL])
        else $error("disabled pwm not at polarity level");
    a_ovf_toggles: assert property (
        steady && run && ctrl_q[`CTRL_OVF_MODE] && count_tick
        && counter_value == 16'h0 ##1 counter_value != 16'h0
        |-> ##[0:3] $changed(overflow_out))
        else $error("overflow output did not toggle");
    a_irq_masked: assert property (
        ien_q == 7'h0 && ien_p1 == 7'h0 && ien_p2 == 7'h0 |-> !irq)
        else $error("interrupt with all enables off");
endmodule

// ---- timer_pin_partner.sv ----
// event pin source and output load monitor for the timer
`timescale 1ns/1ps
module timer_pin_partner (
    input wire logic pclk,
    input wire logic pwm_out,
    input wire logic overflow_out,
    output logic event_in_a,
    output logic event_in_b,
    output int pwm_rises,
    output int ovf_changes
);
    logic pwm_prev, ovf_prev;

    // idle levels: a high, b low
    initial begin
        event_in_a = 1'b1;
        event_in_b = 1'b0;
        pwm_rises = 0;
        ovf_changes = 0;
        pwm_prev = 1'b0;
        ovf_prev = 1'b0;
    end

    // load side: count pwm rises and overflow changes
    always @(posedge pclk) begin
        if (pwm_out === 1'b1 && pwm_prev === 1'b0) pwm_rises++;
        if (overflow_out !== ovf_prev) ovf_changes++;
        pwm_prev <= pwm_out;
        ovf_prev <= overflow_out;
    end

    // change both pins just after a clock edge
    task drive(input logic a, input logic b);
        @(posedge pclk);
        event_in_a <= a;
        event_in_b <= b;
    endtask
endmodule

// ---- testbench.sv ----
// self-checking testbench of the auto-reload timer block
`timescale 1ns/1ps
`include "autoreload_timer_params.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, count_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, pwm_out, overflow_out, irq, rerr;
    logic event_in_a, event_in_b;
    logic [15:0] counter_value;
    int pwm_rises, ovf_changes, n_mismatch, cmp_count, p0, o0;

    autoreload_timer_capture i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_tick(count_tick),
        .event_in_a(event_in_a), .event_in_b(event_in_b),
        .pwm_out(pwm_out), .overflow_out(overflow_out), .irq(irq),
        .counter_value(counter_value));
    timer_pin_partner i_pins (.pclk(pclk), .pwm_out(pwm_out),
        .overflow_out(overflow_out), .event_in_a(event_in_a),
        .event_in_b(event_in_b), .pwm_rises(pwm_rises),
        .ovf_changes(ovf_changes));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task give_verdict;
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("mismatch at %0t: count %0d", $time, got);
        end
    endtask
    // a hung slave is ended by the watchdog only
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task rds(input logic [31:0] exp);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk(rdat & 32'hf, exp);
    endtask
    task pins(input logic a, input logic b);
        i_pins.drive(a, b);
        repeat (8) @(posedge pclk);
    endtask
    task tick(input int n);
        @(posedge pclk);
        count_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        count_tick <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task s_regs;
        rd(`OFS_MASK, 32'hffff);
        bus(1'b0, 8'h20, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(`OFS_CAPTURE, 32'h1234);
        rd(`OFS_CAPTURE, 32'h0);
        wr(`OFS_RELOAD_CAPTURE, 32'h5555);
        rd(`OFS_RELOAD_CAPTURE, 32'h0);
    endtask
    task s_free_run;
        wr(`OFS_CTRL, 32'h201);
        tick(5);
        rd(`OFS_COUNTER, 32'hfffb);
        pins(1'b1, 1'b1);
        rd(`OFS_CAPTURE, 32'hfffb);
        pins(1'b1, 1'b0);
        rds(32'h4);
        tick(3);
        pins(1'b0, 1'b1);
        rd(`OFS_RELOAD_CAPTURE, 32'hfff8);
        rd(`OFS_CAPTURE, 32'hfffb);
        rds(32'hd);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_INT_EN, 32'h4);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_STATUS, 32'hf);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_CTRL, 32'h0);
        rd(`OFS_COUNTER, 32'h0);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b1);
        rds(32'h0);
        pins(1'b1, 1'b0);
        wr(`OFS_INT_EN, 32'h0);
    endtask
    task s_restart_b;
        wr(`OFS_CTRL, 32'h20a);
        wr(`OFS_RELOAD_CAPTURE, 32'h100);
        wr(`OFS_CTRL, 32'h20b);
        tick(3);
        pins(1'b1, 1'b1);
        rd(`OFS_CAPTURE, 32'h0);
        rd(`OFS_COUNTER, 32'h100);
        tick(4);
        pins(1'b0, 1'b1);
        rd(`OFS_COUNTER, 32'hfc);
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        rd(`OFS_COUNTER, 32'h100);
        rd(`OFS_CAPTURE, 32'h0);
        rds(32'hd);
        rd(`OFS_RELOAD_CAPTURE, 32'h100);
        wr(`OFS_STATUS, 32'hf);
        wr(`OFS_CTRL, 32'h20a);
        pins(1'b1, 1'b0);
    endtask
    task s_restart_a;
        wr(`OFS_RELOAD_CAPTURE, 32'h200);
        wr(`OFS_CTRL, 32'h207);
        pins(1'b0, 1'b0);
        rd(`OFS_COUNTER, 32'h200);
        rds(32'h1);
        tick(2);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b1);
        rd(`OFS_CAPTURE, 32'h1fe);
        rd(`OFS_COUNTER, 32'h200);
        rds(32'h7);
        wr(`OFS_STATUS, 32'hf);
        wr(`OFS_CTRL, 32'h202);
        pins(1'b1, 1'b0);
    endtask
    // pin a set to rising here, so both polarities of a are used
    task s_soft;
        wr(`OFS_CTRL, 32'h303);
        rd(`OFS_COUNTER, 32'h200);
        tick(1);
        pins(1'b1, 1'b1);
        rd(`OFS_CAPTURE, 32'h1ff);
        wr(`OFS_STATUS, 32'hf);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        rds(32'h1);
        wr(`OFS_STATUS, 32'hf);
        wr(`OFS_CTRL, 32'h2);
    endtask
    task s_waves;
        wr(`OFS_RELOAD_CAPTURE, 32'h7);
        wr(`OFS_COMPARE, 32'h3);
        wr(`OFS_CTRL, 32'hbf);
        count_tick <= 1'b1;
        p0 = pwm_rises;
        o0 = ovf_changes;
        repeat (80) @(posedge pclk);
        rng(pwm_rises - p0, 9, 11);
        rng(ovf_changes - o0, 9, 11);
        wr(`OFS_CTRL, 32'hff);
        p0 = pwm_rises;
        repeat (80) @(posedge pclk);
        rng(pwm_rises - p0, 4, 6);
        wr(`OFS_CTRL, 32'h9f);
        repeat (3) @(posedge pclk);
        chk({31'h0, pwm_out}, 32'h1);
        wr(`OFS_CTRL, 32'h1f);
        repeat (3) @(posedge pclk);
        chk({31'h0, pwm_out}, 32'h0);
        wr(`OFS_CTRL, 32'hf);
        repeat (20) @(posedge pclk);
        chk({31'h0, overflow_out}, 32'h1);
        count_tick <= 1'b0;
        wr(`OFS_STATUS, 32'h10);
        repeat (3) @(posedge pclk);
        chk({31'h0, overflow_out}, 32'h0);
    endtask

    // ----------------------------------------
    // clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, count_tick} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        s_regs;
        s_free_run;
        s_restart_b;
        s_restart_a;
        s_soft;
        s_waves;
        give_verdict;
    end
    initial begin
        #(20000 * 25);
        n_mismatch++;
        give_verdict;
    end
endmodule

bind autoreload_timer_capture autoreload_timer_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
    .event_in_a(event_in_a), .event_in_b(event_in_b), .pwm_out(pwm_out),
    .overflow_out(overflow_out), .irq(irq), .counter_value(counter_value));
